//--- scc_pkg.sv
package scc_pkg;
    // register word offsets on the avalon bus (byte addresses)
    localparam logic [3:0] REG_CLKS = 4'h0;
    localparam logic [3:0] REG_COP = 4'h4;
    localparam logic [3:0] REG_MISC = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // clock select field positions
    localparam int CLKS_PLL_BUS_CLK_SEL = 7;
    localparam int CLKS_PSEUDO_STOP_SEL = 6;
    localparam int CLKS_WATCHDOG_STOP_CLK_DISABLE = 5;
    localparam int CLKS_WDHI = 4;
    localparam int CLKS_PRE = 3;
    localparam int CLKS_PCE = 2;
    localparam int CLKS_TICK = 1;
    localparam int CLKS_WDLO = 0;
    // cop register fields
    localparam int COP_FRZ = 6;
    localparam int COP_RATE_LO = 0;
    // misc register fields
    localparam int MISC_CRYSTAL_OSC_ENABLE = 0;
    localparam int MISC_SENSE_VOLTAGE_SEL = 1;
    localparam int MISC_PERIODIC_OUT_SEL = 2;
    localparam int MISC_PERIODIC_OUT_EN = 3;
    localparam logic [7:0] CLKS_RST = 8'h80;
    localparam logic [7:0] COP_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [2:0] RATE_MAX = 3'h7;
    // added latency for rc clock gating, in ns
    localparam int WATCHDOG_STOP_CLK_DISABLE_LAT_NS = 100;
    localparam int CLK_NS = 10;
    localparam int WATCHDOG_STOP_CLK_DISABLE_LAT_CYC = (WATCHDOG_STOP_CLK_DISABLE_LAT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_STOP,
        ST_EXIT
    } scc_state_t;

    // clock enables handed to the clock tree
    typedef struct packed {
        logic core_bus;
        logic pll;
        logic ref_osc;
        logic crystal;
        logic rc_wd;
        logic wd_run;
        logic tick_run;
        logic api_run;
    } scc_clk_en_t;

    // regulator controls
    typedef struct packed {
        logic reduced_performance;
        logic low_volt_irq_en;
        logic low_volt_reset_en;
        logic por_en;
    } scc_reg_ctl_t;
endpackage

//--- scc_stop_ctl.sv
module scc_stop_ctl #(
    parameter int LAT_CYC = scc_pkg::WATCHDOG_STOP_CLK_DISABLE_LAT_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic stop_req_i,
    input wire logic wakeup_i,
    input wire logic debug_active_i,
    input wire logic reset_pin_n_i,
    input wire logic int_reset_i,
    input wire logic api_clk_i,
    input wire logic rc_clk_i,
    input wire logic temp_sensor_out_i,
    input wire logic bandgap_i,
    output logic reset_pin_n_o,
    output logic reset_pin_oe_n_o,
    output logic device_reset_o,
    output logic stop_ack_o,
    output logic run_o,
    output scc_pkg::scc_clk_en_t clk_en_o,
    output scc_pkg::scc_reg_ctl_t reg_ctl_o,
    output logic bus_on_pll_o,
    output logic wd_on_rc_o,
    output logic tick_on_crystal_o,
    output logic crystal_input_pd_o,
    output logic crystal_drive_pd_o,
    output logic periodic_clock_out_o,
    output logic periodic_clock_oe_o,
    output logic [2:0] watchdog_rate_o,
    output logic sense_channel_o
);
    // latency counter is 8 bits wide; refuse what it cannot count
    if (LAT_CYC < 1 || LAT_CYC > 255) begin : g_lat_chk
        $error("LAT_CYC out of range");
    end

    logic [7:0] clks, next_clks;
    logic [7:0] system_watchdog, next_cop;
    logic [7:0] misc, next_misc;
    scc_pkg::scc_state_t state, next_state;
    logic pseudo, next_pseudo;
    logic [7:0] lat, next_lat;
    logic [31:0] rdata, next_rdata;
    logic wait_q, next_wait_q;
    scc_pkg::scc_clk_en_t next_clk_en;
    scc_pkg::scc_reg_ctl_t next_reg_ctl;
    logic next_rst_drv;
    logic next_wd_rc, next_tick_x;
    logic pseudo_now, wd_hi, watchdog_stop_clk_disable, in_stop, frz;

    assign wd_hi = clks[scc_pkg::CLKS_WDHI];
    assign watchdog_stop_clk_disable = clks[scc_pkg::CLKS_WATCHDOG_STOP_CLK_DISABLE];
    // pseudo only when both bits set
    assign pseudo_now = clks[scc_pkg::CLKS_PSEUDO_STOP_SEL] &
        misc[scc_pkg::MISC_CRYSTAL_OSC_ENABLE];
    assign in_stop = (state != scc_pkg::ST_RUN);
    // debug freeze: counters hold, run mode otherwise
    assign frz = debug_active_i & system_watchdog[scc_pkg::COP_FRZ];

    // bus slave: one wait state, then answer
    always_comb begin
        next_wait_q = 1'b0;
        next_rdata = rdata;
        next_clks = clks;
        next_cop = system_watchdog;
        next_misc = misc;
        if ((avs_read_i | avs_write_i) & ~wait_q) begin
            next_wait_q = 1'b1;
        end
        if (avs_read_i & ~wait_q) begin
            unique case (avs_address_i)
                scc_pkg::REG_CLKS: next_rdata = {24'h000000, clks};
                scc_pkg::REG_COP: next_rdata = {24'h000000, system_watchdog};
                scc_pkg::REG_MISC: next_rdata = {24'h000000, misc};
                scc_pkg::REG_STAT: next_rdata = {28'h0000000,
                    pseudo, in_stop, frz, ~reset_pin_n_i};
                default: next_rdata = 32'h00000000;
            endcase
        end
        if (avs_write_i & wait_q & avs_byteenable_i[0]) begin
            unique case (avs_address_i)
                scc_pkg::REG_CLKS: next_clks = avs_writedata_i[7:0];
                scc_pkg::REG_COP: next_cop = avs_writedata_i[7:0];
                scc_pkg::REG_MISC: next_misc = avs_writedata_i[7:0];
                default: ;
            endcase
        end
        // wake from full stop: pll and tick selects restored, wd lo cleared only with wd hi 0
        if (state == scc_pkg::ST_EXIT && !pseudo) begin
            next_clks[scc_pkg::CLKS_PLL_BUS_CLK_SEL] = 1'b1;
            next_clks[scc_pkg::CLKS_TICK] = 1'b0;
            if (!wd_hi) begin
                next_clks[scc_pkg::CLKS_WDLO] = 1'b0;
            end
        end
        // pseudo exit touches no select bits
    end

    // stop sequencer; latency only with rc source and watchdog_stop_clk_disable
    always_comb begin
        next_state = state;
        next_pseudo = pseudo;
        next_lat = lat;
        unique case (state)
            scc_pkg::ST_RUN: begin
                if (stop_req_i) begin
                    next_pseudo = pseudo_now;
                    next_lat = (wd_hi & watchdog_stop_clk_disable) ? LAT_CYC[7:0] : 8'h00;
                    next_state = scc_pkg::ST_ENTER;
                end
            end
            scc_pkg::ST_ENTER: begin
                if (lat == 8'h00) begin
                    next_state = scc_pkg::ST_STOP;
                end else begin
                    next_lat = lat - 8'h01;
                end
            end
            scc_pkg::ST_STOP: begin
                if (wakeup_i) begin
                    next_lat = (wd_hi & watchdog_stop_clk_disable) ? LAT_CYC[7:0] : 8'h00;
                    next_state = scc_pkg::ST_EXIT;
                end
            end
            scc_pkg::ST_EXIT: begin
                if (lat == 8'h00) begin
                    next_state = scc_pkg::ST_RUN;
                end else begin
                    next_lat = lat - 8'h01;
                end
            end
        endcase
    end

    // clock enables and regulator controls for the current state
    always_comb begin
        logic stopped;
        stopped = (next_state == scc_pkg::ST_STOP);
        next_clk_en.core_bus = ~stopped;
        next_clk_en.pll = ~stopped;
        next_clk_en.ref_osc = ~stopped;
        next_clk_en.api_run = 1'b1;
        // crystal: off in full stop, on in pseudo
        next_clk_en.crystal = misc[scc_pkg::MISC_CRYSTAL_OSC_ENABLE] &
            (~stopped | pseudo);
        // rc clock for watchdog, gated in stop when wd_hi and watchdog_stop_clk_disable both set
        next_clk_en.rc_wd = ~(stopped & wd_hi & watchdog_stop_clk_disable);
        if (frz) begin
            next_clk_en.wd_run = 1'b0;
            next_clk_en.tick_run = 1'b0;
        end else if (!stopped) begin
            next_clk_en.wd_run = 1'b1;
            next_clk_en.tick_run = 1'b1;
        end else if (!pseudo) begin
            next_clk_en.tick_run = 1'b0;
            next_clk_en.wd_run = wd_hi & ~watchdog_stop_clk_disable;
        end else if (!wd_hi) begin
            next_clk_en.wd_run = clks[scc_pkg::CLKS_PCE] &
                clks[scc_pkg::CLKS_PRE];
            next_clk_en.tick_run = clks[scc_pkg::CLKS_PCE] &
                clks[scc_pkg::CLKS_PRE];
        end else begin
            next_clk_en.tick_run = clks[scc_pkg::CLKS_PRE];
            next_clk_en.wd_run = ~watchdog_stop_clk_disable;
        end
        next_reg_ctl.reduced_performance = stopped;
        next_reg_ctl.low_volt_irq_en = ~stopped;
        next_reg_ctl.low_volt_reset_en = ~stopped;
        next_reg_ctl.por_en = 1'b1;
        // in pseudo stop the tick counter runs on crystal derived clock
        next_tick_x = stopped & pseudo;
        next_wd_rc = wd_hi;
        // open drain: drive low on any internal reset
        next_rst_drv = int_reset_i;
    end

    // register bank and sequencer state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clks <= scc_pkg::CLKS_RST;
            system_watchdog <= scc_pkg::COP_RST;
            misc <= scc_pkg::MISC_RST;
            state <= scc_pkg::ST_RUN;
            pseudo <= 1'b0;
            lat <= 8'h00;
            rdata <= 32'h00000000;
            wait_q <= 1'b0;
        end else begin
            clks <= next_clks;
            system_watchdog <= next_cop;
            misc <= next_misc;
            state <= next_state;
            pseudo <= next_pseudo;
            lat <= next_lat;
            rdata <= next_rdata;
            wait_q <= next_wait_q;
        end
    end

    // registered outputs; reset values put the chip in run mode
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h00000000;
            avs_waitrequest_o <= 1'b1;
            reset_pin_n_o <= 1'b0;
            reset_pin_oe_n_o <= 1'b1;
            device_reset_o <= 1'b1;
            stop_ack_o <= 1'b0;
            run_o <= 1'b1;
            clk_en_o <= '1;
            reg_ctl_o <= 4'h7;
            bus_on_pll_o <= 1'b1;
            wd_on_rc_o <= 1'b0;
            tick_on_crystal_o <= 1'b0;
            crystal_input_pd_o <= 1'b1;
            crystal_drive_pd_o <= 1'b1;
            periodic_clock_out_o <= 1'b0;
            periodic_clock_oe_o <= 1'b0;
            watchdog_rate_o <= 3'h0;
            sense_channel_o <= 1'b0;
        end else begin
            avs_readdata_o <= next_rdata;
            // low only in the cycle the answer stands
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~wait_q);
            reset_pin_n_o <= 1'b0;
            reset_pin_oe_n_o <= ~next_rst_drv;
            // pin low asynchronously resets through system, seen here
            device_reset_o <= ~reset_pin_n_i | int_reset_i;
            stop_ack_o <= (next_state == scc_pkg::ST_STOP);
            run_o <= (next_state == scc_pkg::ST_RUN);
            clk_en_o <= next_clk_en;
            reg_ctl_o <= next_reg_ctl;
            bus_on_pll_o <= next_clks[scc_pkg::CLKS_PLL_BUS_CLK_SEL];
            wd_on_rc_o <= next_wd_rc;
            tick_on_crystal_o <= next_tick_x |
                next_clks[scc_pkg::CLKS_TICK];
            crystal_input_pd_o <= ~next_misc[scc_pkg::MISC_CRYSTAL_OSC_ENABLE];
            crystal_drive_pd_o <= ~next_misc[scc_pkg::MISC_CRYSTAL_OSC_ENABLE];
            // api clock out: selected source, gated by enable
            periodic_clock_out_o <= next_misc[scc_pkg::MISC_PERIODIC_OUT_EN] &
                (next_misc[scc_pkg::MISC_PERIODIC_OUT_SEL] ? api_clk_i
                                                : rc_clk_i);
            periodic_clock_oe_o <= next_misc[scc_pkg::MISC_PERIODIC_OUT_EN];
            // debug forces slowest rate when freeze bit set
            watchdog_rate_o <= frz ? scc_pkg::RATE_MAX
                : next_cop[2:0];
            sense_channel_o <= next_misc[scc_pkg::MISC_SENSE_VOLTAGE_SEL]
                ? temp_sensor_out_i : bandgap_i;
        end
    end
endmodule

//--- scc_stop_ctl_bench.sv
module scc_stop_ctl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int UPOSC_CYC = 20; // start-up wait, plain default
    logic clk = 0, rst = 1, rd = 0, wr = 0, sreq = 0, wake = 0, dbg = 0;
    logic pin_n = 1, irst = 0, autonomous_periodic_timer = 1, rcc = 0, temp = 1, bg = 0;
    logic [3:0] addr = 4'h0, be = 4'hF;
    logic [31:0] wd = 32'h0, rdq, q;
    logic wt_o, pin_o, oe_n, drst, ack, run, onpll, pdi, pdd, pco, pcoe, sns;
    logic [2:0] rate;
    logic [3:0] rc;
    logic wrc, tx;
    scc_pkg::scc_clk_en_t en;
    int n_mismatch = 0, compares = 0, k;
    int n[6];
    logic [7:0] cv[6] = '{8'h03, 8'h4F, 8'h43, 8'h30, 8'h10, 8'h7C};
    logic [7:0] av[6] = '{8'h80, 8'h4F, 8'h43, 8'hB0, 8'h90, 8'h7C};
    logic [3:0] ev[6] = '{4'h1, 4'hF, 4'h9, 4'h1, 4'h5, 4'hB};
    // open-drain pin: low if either side pulls it, pull-up otherwise
    wire pin_w = pin_n & (oe_n | pin_o);
    scc_stop_ctl #(.LAT_CYC(3)) dut_u (.core_clk_i(clk), .rst_i(rst),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdq),
        .avs_waitrequest_o(wt_o), .stop_req_i(sreq), .wakeup_i(wake),
        .debug_active_i(dbg), .reset_pin_n_i(pin_w), .int_reset_i(irst),
        .api_clk_i(autonomous_periodic_timer), .rc_clk_i(rcc), .temp_sensor_out_i(temp),
        .bandgap_i(bg), .reset_pin_n_o(pin_o), .reset_pin_oe_n_o(oe_n),
        .device_reset_o(drst), .stop_ack_o(ack), .run_o(run), .clk_en_o(en),
        .reg_ctl_o(rc), .bus_on_pll_o(onpll), .wd_on_rc_o(wrc),
        .tick_on_crystal_o(tx), .crystal_input_pd_o(pdi),
        .crystal_drive_pd_o(pdd), .periodic_clock_out_o(pco),
        .periodic_clock_oe_o(pcoe), .watchdog_rate_o(rate),
        .sense_channel_o(sns));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int c;
        @(posedge clk);
        addr <= a; wr <= w; rd <= !w; wd <= d;
        c = 0;
        do begin @(posedge clk); c++; end while (wt_o !== 1'b0 && c < 50);
        q = rdq;
        rd <= 1'b0; wr <= 1'b0;
        if (c >= 50) begin n_mismatch++; end_sim(); end
    endtask
    task automatic creg(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, 32'(e));
    endtask
    task automatic s(input int c); repeat (c) @(negedge clk); endtask
    // bounded wait for stop acknowledge (sel 1) or run (sel 0)
    task automatic wt(input logic sel, output int c);
        c = 0;
        while ((sel ? ack : run) !== 1'b1 && c < 100) begin s(1); c++; end
        if (c >= 100) begin n_mismatch++; end_sim(); end
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        creg(scc_pkg::REG_CLKS, 8'h80);
        creg(scc_pkg::REG_COP, 8'h00);
        creg(scc_pkg::REG_MISC, 8'h00);
        creg(4'h2, 8'h00);
        chk(32'({onpll, pdi, pdd, oe_n}), 32'hF);
        $display("reset values done");
        be <= 4'h0;
        bus(1'b1, scc_pkg::REG_MISC, 32'h0F);
        be <= 4'hF;
        creg(scc_pkg::REG_MISC, 8'h00);
        bus(1'b1, scc_pkg::REG_MISC, 32'h0F);
        s(3);
        chk(32'({pdi, pdd, sns, pco, pcoe}), 32'h7);
        bus(1'b1, scc_pkg::REG_MISC, 32'h09);
        s(3);
        chk(32'({sns, pco, pcoe}), 32'h1);
        bus(1'b1, scc_pkg::REG_CLKS, 32'h00);
        s(3);
        chk(32'(onpll), 32'h0);
        repeat (UPOSC_CYC) @(posedge clk);
        $display("pin and select outputs done");
        bus(1'b1, scc_pkg::REG_COP, 32'h41);
        s(3);
        chk(32'(rate), 32'h1);
        @(posedge clk) dbg <= 1'b1;
        s(3);
        chk(32'({rate, en.wd_run, en.tick_run}), 32'h1C);
        @(posedge clk) dbg <= 1'b0;
        s(3);
        chk(32'({rate, en.tick_run}), 32'h3);
        $display("debug freeze done");
        // full, pseudo and watchdog-on-rc variants
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, scc_pkg::REG_CLKS, 32'(cv[i]));
            @(posedge clk) sreq <= 1'b1;
            @(posedge clk) sreq <= 1'b0;
            wt(1'b1, n[i]);
            chk(32'({en.crystal, cv[i][4] ? en.rc_wd : en.wd_run,
                     en.tick_run, en.api_run}), 32'(ev[i]));
            chk(32'(rc), 32'h9);
            chk(32'(wrc), 32'(cv[i][4]));
            @(posedge clk) wake <= 1'b1;
            @(posedge clk) wake <= 1'b0;
            wt(1'b0, k);
            creg(scc_pkg::REG_CLKS, av[i]);
            chk(32'(tx), 32'(av[i][1]));
            repeat (UPOSC_CYC) @(posedge clk);
        end
        chk(32'(n[3] > n[0]), 32'h1);
        $display("stop variants done");
        @(posedge clk) irst <= 1'b1;
        s(3);
        chk(32'({oe_n, drst}), 32'h1);
        @(posedge clk) irst <= 1'b0;
        s(4);
        chk(32'(oe_n), 32'h1);
        @(posedge clk) pin_n <= 1'b0;
        s(3);
        chk(32'(drst), 32'h1);
        creg(scc_pkg::REG_STAT, 8'h09);
        @(posedge clk) pin_n <= 1'b1;
        $display("reset pin done");
        end_sim();
    end
endmodule

//--- scc_stop_ctl_properties.sv
module scc_stop_ctl_properties (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic stop_req_i,
    input wire logic wakeup_i,
    input wire logic reset_pin_n_i,
    input wire logic int_reset_i,
    input wire logic reset_pin_oe_n_o,
    input wire logic device_reset_o,
    input wire logic stop_ack_o,
    input wire logic run_o,
    input wire scc_pkg::scc_clk_en_t clk_en_o,
    input wire scc_pkg::scc_reg_ctl_t reg_ctl_o,
    input wire logic crystal_input_pd_o,
    input wire logic crystal_drive_pd_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // entry and wake bounds cover the longest gating latency with margin
    sequence s_enter; stop_req_i && run_o; endsequence
    sequence s_wake; stop_ack_o && wakeup_i; endsequence
    property p_clk_off;
        stop_ack_o |-> !clk_en_o.core_bus && !clk_en_o.pll && !clk_en_o.ref_osc;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock on in stop");
    property p_regu; stop_ack_o |-> reg_ctl_o == 4'h9; endproperty
    a_regu: assert property (p_regu) else $error("regulator ctl wrong");
    property p_api; stop_ack_o |-> clk_en_o.api_run; endproperty
    a_api: assert property (p_api) else $error("periodic timer off");
    property p_enter; s_enter |-> ##[1:40] stop_ack_o; endproperty
    a_enter: assert property (p_enter) else $error("stop not entered");
    property p_wake; s_wake |-> ##[1:40] run_o; endproperty
    a_wake: assert property (p_wake) else $error("no return to run");
    property p_excl; !(run_o && stop_ack_o); endproperty
    a_excl: assert property (p_excl) else $error("run and stop both high");
    property p_wait; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_pin_out; int_reset_i |-> ##[1:2] !reset_pin_oe_n_o; endproperty
    a_pin_out: assert property (p_pin_out) else $error("pin not driven");
    property p_pin_in; !reset_pin_n_i |-> ##[1:2] device_reset_o; endproperty
    a_pin_in: assert property (p_pin_in) else $error("pin reset lost");
    property p_pd;
        stop_ack_o && clk_en_o.crystal |-> !crystal_input_pd_o && !crystal_drive_pd_o;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown with crystal on");
endmodule

bind scc_stop_ctl scc_stop_ctl_properties chk_u (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .stop_req_i(stop_req_i),
    .wakeup_i(wakeup_i), .reset_pin_n_i(reset_pin_n_i),
    .int_reset_i(int_reset_i), .reset_pin_oe_n_o(reset_pin_oe_n_o),
    .device_reset_o(device_reset_o), .stop_ack_o(stop_ack_o), .run_o(run_o),
    .clk_en_o(clk_en_o), .reg_ctl_o(reg_ctl_o),
    .crystal_input_pd_o(crystal_input_pd_o),
    .crystal_drive_pd_o(crystal_drive_pd_o));
